// ---- design/serial_port_defines.vh ----
// Purpose: constants for the secondary serial channel data path
// Assumes: 10-bit I/O addresses, 8-bit data bus
// Notes: definitions only
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

`define SER_BASE_ADDR 10'h2f8
`define SER_TOP_ADDR 10'h2ff
`define SER_OFS_DATA 3'h0
`define SER_OFS_IER 3'h1
`define SER_OFS_LCR 3'h3
`define SER_OFS_LSR 3'h5
`define SER_LCR_DIV_ACCESS_BIT 7
`define SER_LCR_BREAK_BIT 6
`define SER_LSR_WAITING_BIT 0
`define SER_LSR_OE_BIT 1
`define SER_LSR_THRE_BIT 5
`define SER_LSR_TEMT_BIT 6
`define SER_IER_MASK 8'h0f
`define SER_LCR_RESET 8'h03
`define SER_DIV_RESET 16'h0001
`define SER_OVERSAMPLE 5'h10
`define SER_MID_SAMPLE 5'h08

`endif

// ---- design/char_buffer.v ----
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: in_ready_out low only when both entries hold data
`timescale 1ns/1ps
module char_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);
  reg [WIDTH-1:0] entry_q [0:1];
  reg rd_idx_q;
  reg wr_idx_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  assign in_ready_out = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out = entry_q[rd_idx_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always @(posedge clk_in) begin
    if (reset_in) begin
      rd_idx_q <= 1'b0;
      wr_idx_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        entry_q[wr_idx_q] <= in_data_in;
        wr_idx_q <= ~wr_idx_q;
      end
      if (pop) begin
        rd_idx_q <= ~rd_idx_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// ---- design/secondary_serial_port.v ----
// Purpose: data path of the secondary serial channel on the I/O bus
// Assumes: bus strobes and serial input are synchronous to clk_in; 8N1 framing
// Notes: reads are registered, data appears one cycle after the read strobe
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module secondary_serial_port (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // host I/O bus
  input wire [9:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // serial line
  input wire serial_rx_in,
  output reg serial_tx_out
);
  localparam TX_IDLE = 2'h0;
  localparam TX_START = 2'h1;
  localparam TX_DATA = 2'h2;
  localparam TX_STOP = 2'h3;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  reg [7:0] lcr_q;
  reg [7:0] ier_q;
  reg [15:0] divisor_q;
  reg [15:0] div_cnt_q;
  reg tick_q;
  reg [7:0] thr_q;
  reg thr_full_q;
  reg overrun_q;
  reg [1:0] tx_state_q;
  reg [7:0] tx_shift_q;
  reg [2:0] tx_bit_q;
  reg [3:0] tx_sub_q;
  reg [1:0] rx_state_q;
  reg [7:0] rx_shift_q;
  reg [2:0] rx_bit_q;
  reg [3:0] rx_sub_q;
  reg rx_push_q;

  wire [9:0] base_addr = `SER_BASE_ADDR;
  wire in_block = (addr_in[9:3] == base_addr[9:3])
    && (addr_in <= `SER_TOP_ADDR);
  wire [2:0] ofs = addr_in[2:0];
  wire divisor_access_select = lcr_q[`SER_LCR_DIV_ACCESS_BIT];
  wire wr_hit = wr_in && in_block;
  wire rd_hit = rd_in && in_block;
  wire rbr_pop = rd_hit && (ofs == `SER_OFS_DATA) && !divisor_access_select;
  wire thr_load = wr_hit && (ofs == `SER_OFS_DATA) && !divisor_access_select;
  wire rx_ready;
  wire rx_valid;
  wire [7:0] rx_head;
  wire tx_take = (tx_state_q == TX_IDLE) && thr_full_q && tick_q;
  wire [7:0] lsr_val;

  assign lsr_val = {1'b0, !thr_full_q && (tx_state_q == TX_IDLE), !thr_full_q,
    3'h0, overrun_q, rx_valid};

  char_buffer #(
    .WIDTH(8)
  ) rx_buf (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(rx_push_q),
    .in_data_in(rx_shift_q),
    .in_ready_out(rx_ready),
    .out_valid_out(rx_valid),
    .out_data_out(rx_head),
    .out_ready_in(rbr_pop)
  );

  // registers and read path
  always @(posedge clk_in) begin
    if (reset_in) begin
      lcr_q <= `SER_LCR_RESET;
      ier_q <= 8'h00;
      divisor_q <= `SER_DIV_RESET;
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
      overrun_q <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      if (wr_hit) begin
        case (ofs)
          `SER_OFS_DATA: begin
            if (divisor_access_select) begin
              divisor_q[7:0] <= wdata_in;
            end else begin
              thr_q <= wdata_in;
            end
          end
          `SER_OFS_IER: begin
            if (divisor_access_select) begin
              divisor_q[15:8] <= wdata_in;
            end else begin
              ier_q <= wdata_in & `SER_IER_MASK;
            end
          end
          `SER_OFS_LCR: lcr_q <= wdata_in;
          default: lcr_q <= lcr_q;
        endcase
      end
      if (thr_load) begin
        thr_full_q <= 1'b1;
      end else if (tx_take) begin
        thr_full_q <= 1'b0;
      end
      // a new overrun wins over the clearing read
      if (rx_push_q && !rx_ready) begin
        overrun_q <= 1'b1;
      end else if (rd_hit && ofs == `SER_OFS_LSR) begin
        overrun_q <= 1'b0;
      end
      if (rd_hit) begin
        case (ofs)
          `SER_OFS_DATA: begin
            rdata_out <= divisor_access_select ? divisor_q[7:0] : rx_head;
          end
          `SER_OFS_IER: begin
            rdata_out <= divisor_access_select ? divisor_q[15:8] : ier_q;
          end
          `SER_OFS_LCR: rdata_out <= lcr_q;
          `SER_OFS_LSR: rdata_out <= lsr_val;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // sixteen-times bit clock enable
  always @(posedge clk_in) begin
    if (reset_in) begin
      div_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (divisor_q == 16'h0000) begin
      div_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_cnt_q >= divisor_q - 16'h0001) begin
      div_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // transmitter
  always @(posedge clk_in) begin
    if (reset_in) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_sub_q <= 4'h0;
      serial_tx_out <= 1'b1;
    end else begin
      if (tick_q) begin
        tx_sub_q <= tx_sub_q + 4'h1;
        case (tx_state_q)
          TX_IDLE: begin
            tx_sub_q <= 4'h0;
            if (thr_full_q) begin
              tx_shift_q <= thr_q;
              tx_state_q <= TX_START;
            end
          end
          TX_START: begin
            if (tx_sub_q == 4'hf) begin
              tx_state_q <= TX_DATA;
              tx_bit_q <= 3'h0;
            end
          end
          TX_DATA: begin
            if (tx_sub_q == 4'hf) begin
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
              if (tx_bit_q == 3'h7) begin
                tx_state_q <= TX_STOP;
              end
            end
          end
          TX_STOP: begin
            if (tx_sub_q == 4'hf) begin
              tx_state_q <= TX_IDLE;
            end
          end
          default: tx_state_q <= TX_IDLE;
        endcase
      end
      if (lcr_q[`SER_LCR_BREAK_BIT]) begin
        serial_tx_out <= 1'b0;
      end else begin
        case (tx_state_q)
          TX_START: serial_tx_out <= 1'b0;
          TX_DATA: serial_tx_out <= tx_shift_q[0];
          default: serial_tx_out <= 1'b1;
        endcase
      end
    end
  end

  // receiver, sampling each bit at its middle
  always @(posedge clk_in) begin
    if (reset_in) begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_sub_q <= 4'h0;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      if (tick_q) begin
        rx_sub_q <= rx_sub_q + 4'h1;
        case (rx_state_q)
          RX_IDLE: begin
            rx_sub_q <= 4'h0;
            if (!serial_rx_in) begin
              rx_state_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_sub_q == 4'h7) begin
              rx_sub_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_state_q <= serial_rx_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_sub_q == 4'hf) begin
              rx_shift_q <= {serial_rx_in, rx_shift_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_sub_q == 4'hf) begin
              rx_push_q <= serial_rx_in;
              rx_state_q <= RX_IDLE;
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- test/secondary_serial_port_assertions.sv ----
// Purpose: port-level checks of the serial data path
// Assumes: back-to-back accesses separated by one idle cycle
// Notes: divisor access bit tracked from line control writes
`timescale 1ns/1ps
module secondary_serial_port_assertions (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // host bus
  input wire [9:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  // serial line
  input wire serial_rx_in,
  input wire serial_tx_out
);
  reg divisor_access_select_q;
  always @(posedge clk_in) begin
    if (reset_in) begin
      divisor_access_select_q <= 1'b0;
    end else if (wr_in && addr_in == 10'h2fb) begin
      divisor_access_select_q <= wdata_in[7];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_idle_after_reset: assert property (
    $fell(reset_in) |-> serial_tx_out && rdata_out == 8'h00) else $error("not idle after reset");
  a_rdata_holds: assert property (
    !(rd_in && addr_in[9:3] == 7'h5f) |=> $stable(rdata_out)) else $error("rdata moved");
  a_unmapped_zero: assert property (
    rd_in && (addr_in == 10'h2fa || addr_in == 10'h2fc || addr_in[9:1] == 9'h17f)
    |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  a_lsr_spare_zero: assert property (
    rd_in && addr_in == 10'h2fd |=> rdata_out[7] == 1'b0 && rdata_out[4:2] == 3'h0)
    else $error("status spare bits set");
  a_ier_upper_zero: assert property (
    rd_in && addr_in == 10'h2f9 && !divisor_access_select_q |=> rdata_out[7:4] == 4'h0)
    else $error("enable upper bits set");
  a_lcr_readback: assert property (
    wr_in && addr_in == 10'h2fb ##2 rd_in && addr_in == 10'h2fb
    |=> rdata_out == $past(wdata_in, 3)) else $error("line control readback");
  a_div_low_back: assert property (
    wr_in && addr_in == 10'h2f8 && divisor_access_select_q ##2 rd_in && addr_in == 10'h2f8
    |=> rdata_out == $past(wdata_in, 3)) else $error("divisor low readback");
  a_div_high_back: assert property (
    wr_in && addr_in == 10'h2f9 && divisor_access_select_q ##2 rd_in && addr_in == 10'h2f9
    |=> rdata_out == $past(wdata_in, 3)) else $error("divisor high readback");
endmodule

// ---- test/remote_serial_model.sv ----
// Purpose: remote serial equipment on the far side of the line
// Assumes: 8N1 framing, bit length given in clock cycles
// Notes: line idles high between frames
`timescale 1ns/1ps
module remote_serial_model (
  // clock and bit length
  input wire clk_in,
  input wire [15:0] bit_cyc_in,
  // serial line
  input wire line_in,
  output reg line_out
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    // start each frame on a clock edge
    @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bit_cyc_in) @(posedge clk_in);
    end
  endtask
  // sample each bit in its middle
  always begin
    @(negedge line_in);
    repeat (bit_cyc_in / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc_in) @(posedge clk_in);
      sh[i] = line_in;
    end
    repeat (bit_cyc_in) @(posedge clk_in);
    got.push_back(sh);
  end
endmodule

// ---- test/secondary_serial_port_data_path_test.sv ----
// Purpose: self-checking bench of the serial data path
// Assumes: divisor 1 after reset, sixteen ticks a bit
// Notes: expected characters kept in a queue
`timescale 1ns/1ps
module secondary_serial_port_data_path_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [9:0] addr_in = 10'h2f8;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] d;
  logic [15:0] bitc = 16'h0010;
  logic [31:0] seed = 32'h33a96c9b;
  logic [7:0] exp_q[$];
  wire [7:0] rdata_out;
  wire tx;
  wire rx;
  int fail_count = 0;
  int tests_run = 0;
  always #50 clk_in = ~clk_in;
  secondary_serial_port dut_u (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .serial_rx_in(rx), .serial_tx_out(tx));
  remote_serial_model remote_u (.clk_in(clk_in), .bit_cyc_in(bitc), .line_in(tx),
    .line_out(rx));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= x;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 x = rdata_out;
  endtask
  task automatic tx_char(input logic [7:0] x);
    wr(10'h2f8, x);
    for (int i = 0; i < 12 * bitc && remote_u.got.size() == 0; i++) @(posedge clk_in);
    chk("tx char", x, remote_u.got.size() ? remote_u.got.pop_front() : 8'hxx);
    // let the stop bit finish so the shifter is idle again
    repeat (bitc) @(posedge clk_in);
    rd(10'h2fd, d);
    chk("status after tx", 8'h60, d);
  endtask
  task automatic rx_chars(input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(rnd());
      remote_u.send(exp_q[$]);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_in);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(10'h2fd, d);
    chk("status idle", 8'h60, d);
    wr(10'h0f8, 8'h5a);
    rd(10'h2fe, d);
    chk("unmapped read", 8'h00, d);
    for (int i = 0; i < 3; i++) tx_char(rnd());
    rx_chars(2);
    rd(10'h2fd, d);
    chk("char waiting", 8'h61, d);
    for (int i = 0; i < 2; i++) begin
      rd(10'h2f8, d);
      chk("rx char", exp_q.pop_front(), d);
    end
    rx_chars(3);
    rd(10'h2fd, d);
    chk("overrun", 8'h63, d);
    rd(10'h2fd, d);
    chk("overrun cleared", 8'h61, d);
    for (int i = 0; i < 2; i++) begin
      rd(10'h2f8, d);
      chk("rx after overrun", exp_q.pop_front(), d);
    end
    void'(exp_q.pop_front());
    rd(10'h2fd, d);
    chk("buffer drained", 8'h60, d);
    // base plus one with divisor access clear is the enable register, low nibble only
    wr(10'h2f9, 8'hff);
    rd(10'h2f9, d);
    chk("enable reg", 8'h0f, d);
    wr(10'h2fb, 8'h83);
    rd(10'h2fb, d);
    chk("line control", 8'h83, d);
    wr(10'h2f8, 8'h02);
    rd(10'h2f8, d);
    chk("divisor low", 8'h02, d);
    wr(10'h2f9, 8'h00);
    rd(10'h2f9, d);
    chk("divisor high", 8'h00, d);
    wr(10'h2fb, 8'h03);
    bitc <= 16'h0020;
    tx_char(rnd());
    rx_chars(1);
    rd(10'h2f8, d);
    chk("rx slow char", exp_q.pop_front(), d);
    // break forces the line low; the far side sees one all-zero frame
    wr(10'h2fb, 8'h43);
    repeat (4) @(posedge clk_in);
    chk("break line", 8'h00, {7'h00, tx});
    repeat (12 * bitc) @(posedge clk_in);
    wr(10'h2fb, 8'h03);
    d = remote_u.got.size() ? remote_u.got.pop_front() : 8'hxx;
    chk("break frame", 8'h00, d);
    give_verdict();
  end
endmodule
bind secondary_serial_port secondary_serial_port_assertions chk_u (.clk_in(clk_in),
  .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out));
